// >>> design/adcs_sequencer.sv
// Purpose: successive-approximation converter control sequencer
// Assumes: core clock equals two oscillator periods; comparator is external
// Notes: on/select/channel are software level inputs; go set/clear are pulses
`timescale 1ns/1ns
module adcs_sequencer (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic converter_on_bit_i,
  input wire logic go_set_i,
  input wire logic go_clear_i,
  input wire logic [2:0] conv_clock_select_i,
  input wire logic result_justify_bit_i,
  input wire logic [3:0] channel_select_i,
  input wire logic rc_osc_i,
  input wire logic cmp_i,
  input wire logic result_wr_high_i,
  input wire logic result_wr_low_i,
  input wire logic [7:0] result_wr_data_i,
  input wire logic [7:0] port_pins_i,
  input wire logic [7:0] analog_mask_i,
  input wire logic done_flag_clear_i,
  output logic go_flag_o,
  output logic conversion_done_flag_o,
  output logic sampling_o,
  output logic [9:0] dac_code_o,
  output logic [7:0] result_high_byte_o,
  output logic [7:0] result_low_byte_o,
  output logic [7:0] port_read_o
);
  import adcs_pkg::*;
  adcs_state_e state_r;
  logic [3:0] bitcnt_r;
  logic [9:0] sar_r;
  logic rc_meta_r;
  logic rc_sync_r;
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic tick;
  logic restart_r;
  logic run;
  logic [9:0] final_val;

  // pins and the rc oscillator come from outside the clock domain
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rc_meta_r <= 1'b0;
      rc_sync_r <= 1'b0;
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
      pin_meta_r <= PORT_RST;
      pin_sync_r <= PORT_RST;
    end else begin
      rc_meta_r <= rc_osc_i;
      rc_sync_r <= rc_meta_r;
      cmp_meta_r <= cmp_i;
      cmp_sync_r <= cmp_meta_r;
      pin_meta_r <= port_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // an abort holds the divider clear for one cycle, so the wait is two whole bit periods
  assign run = ((state_r == ST_CONV) || (state_r == ST_WAIT)) && !restart_r;

  // marks the cycle after an abort; a tick still in flight then is stale
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= converter_on_bit_i && (state_r == ST_CONV) && go_clear_i;
    end
  end

  adcs_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .sel_i(conv_clock_select_i),
    .rc_tick_i(rc_sync_r),
    .tick_o(tick)
  );

  // last trial bit decided in bit period 10; period 11 only settles
  assign final_val = {sar_r[9:1], cmp_sync_r};

  // main sequence; an abort clears go and never touches the result
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      go_flag_o <= 1'b0;
      bitcnt_r <= 4'h0;
    end else if (!converter_on_bit_i) begin
      state_r <= ST_OFF;
      go_flag_o <= 1'b0;
      bitcnt_r <= 4'h0;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_r <= ST_ACQ;
        end
        ST_ACQ: begin
          // go only acts with the converter on; the channel has no say here
          if (go_set_i) begin
            state_r <= ST_CONV;
            go_flag_o <= 1'b1;
            bitcnt_r <= 4'h0;
          end
        end
        ST_CONV: begin
          if (go_clear_i) begin
            state_r <= ST_WAIT;
            go_flag_o <= 1'b0;
            bitcnt_r <= 4'h0;
          end else if (tick) begin
            if (bitcnt_r == CONV_BIT_PERIODS - 4'h1) begin
              state_r <= ST_WAIT;
              go_flag_o <= 1'b0;
              bitcnt_r <= 4'h0;
            end else begin
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        ST_WAIT: begin
          if (tick && !restart_r) begin
            if (bitcnt_r == WAIT_BIT_PERIODS - 4'h1) begin
              state_r <= ST_ACQ;
              bitcnt_r <= 4'h0;
            end else begin
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= ST_OFF;
          go_flag_o <= 1'b0;
        end
      endcase
    end
  end

  // hold capacitor tracks the pin only while acquiring
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sampling_o <= 1'b0;
    end else begin
      sampling_o <= (state_r == ST_ACQ) && converter_on_bit_i && !go_set_i;
    end
  end

  // successive approximation: bit periods 1..10 resolve bits 9..0, 0 and 11 settle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sar_r <= RESULT_RST;
      dac_code_o <= RESULT_RST;
    end else if (state_r == ST_ACQ && go_set_i) begin
      sar_r <= 10'h200;
      dac_code_o <= 10'h200;
    end else if (state_r == ST_CONV && tick && bitcnt_r >= 4'h1 && bitcnt_r <= 4'ha) begin
      // the pin level is whatever is driven, digital output or analog
      sar_r <= sar_r;
      if (bitcnt_r != 4'ha) begin
        sar_r[4'ha - bitcnt_r] <= cmp_sync_r;
        sar_r[4'h9 - bitcnt_r] <= 1'b1;
        dac_code_o <= (sar_r & ~(10'h001 << (4'ha - bitcnt_r))) |
                      ({9'h000, cmp_sync_r} << (4'ha - bitcnt_r)) |
                      (10'h001 << (4'h9 - bitcnt_r));
      end else begin
        sar_r <= final_val;
        dac_code_o <= final_val;
      end
    end
  end

  // result bytes change only on completion or a software write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      result_high_byte_o <= 8'h00;
      result_low_byte_o <= 8'h00;
    end else if (converter_on_bit_i && state_r == ST_CONV && tick && !go_clear_i &&
                 bitcnt_r == CONV_BIT_PERIODS - 4'h1) begin
      if (result_justify_bit_i) begin
        result_high_byte_o <= {6'h00, sar_r[9:8]};
        result_low_byte_o <= sar_r[7:0];
      end else begin
        result_high_byte_o <= sar_r[9:2];
        result_low_byte_o <= {sar_r[1:0], 6'h00};
      end
    end else begin
      if (result_wr_high_i) begin
        result_high_byte_o <= result_wr_data_i;
      end
      if (result_wr_low_i) begin
        result_low_byte_o <= result_wr_data_i;
      end
    end
  end

  // done flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      conversion_done_flag_o <= 1'b0;
    end else if (converter_on_bit_i && state_r == ST_CONV && tick && !go_clear_i &&
                 bitcnt_r == CONV_BIT_PERIODS - 4'h1) begin
      conversion_done_flag_o <= 1'b1;
    end else if (done_flag_clear_i) begin
      conversion_done_flag_o <= 1'b0;
    end
  end

  // analog pins read low regardless of their level
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      port_read_o <= PORT_RST;
    end else begin
      port_read_o <= pin_sync_r & ~analog_mask_i;
    end
  end
endmodule

// >>> design/adcs_pkg.sv
// Purpose: shared constants for the conversion sequencer
// Assumes: core clock 25 MHz, period 40 ns
// Notes: clock select codes map to oscillator periods per bit period
package adcs_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // bit periods per conversion and per post-conversion wait
  localparam logic [3:0] CONV_BIT_PERIODS = 4'hc;
  localparam logic [3:0] WAIT_BIT_PERIODS = 4'h2;
  localparam int RESULT_BITS = 10;
  // clock select encodings
  localparam logic [2:0] SEL_DIV2 = 3'h0;
  localparam logic [2:0] SEL_DIV8 = 3'h1;
  localparam logic [2:0] SEL_DIV32 = 3'h2;
  localparam logic [2:0] SEL_DIV4 = 3'h4;
  localparam logic [2:0] SEL_DIV16 = 3'h5;
  localparam logic [2:0] SEL_DIV64 = 3'h6;
  // half-period counts (oscillator periods per bit period / 2, minus one)
  localparam logic [5:0] DIV2_LAST = 6'h00;
  localparam logic [5:0] DIV4_LAST = 6'h01;
  localparam logic [5:0] DIV8_LAST = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h07;
  localparam logic [5:0] DIV32_LAST = 6'h0f;
  localparam logic [5:0] DIV64_LAST = 6'h1f;
  // reset values
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [7:0] PORT_RST = 8'h00;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10,
    ST_WAIT = 2'b11
  } adcs_state_e;
endpackage

// >>> design/adcs_tick_gen.sv
// Purpose: bit period tick generator
// Assumes: rc_tick_i already synchronous
// Notes: tick_o pulses once per bit period
`timescale 1ns/1ns
module adcs_tick_gen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  input wire logic rc_tick_i,
  output logic tick_o
);
  import adcs_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] last;
  logic phase_r;

  // one core clock stands for two oscillator periods, so the count halves the ratio
  always_comb begin
    case (sel_i)
      SEL_DIV2: last = DIV2_LAST;
      SEL_DIV4: last = DIV4_LAST;
      SEL_DIV8: last = DIV8_LAST;
      SEL_DIV16: last = DIV16_LAST;
      SEL_DIV32: last = DIV32_LAST;
      SEL_DIV64: last = DIV64_LAST;
      default: last = DIV2_LAST;
    endcase
  end

  // divider restarts whenever idle so every bit period is whole
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= 6'h00;
      tick_o <= 1'b0;
      phase_r <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= 6'h00;
      tick_o <= 1'b0;
      // track the rc level while idle so a high rc gives no false first edge
      phase_r <= rc_tick_i;
    end else if (sel_i[1:0] == 2'b11) begin
      phase_r <= rc_tick_i;
      tick_o <= rc_tick_i && !phase_r;
    end else if (cnt_r >= last) begin
      cnt_r <= 6'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> test/adcs_src_model.sv
// Purpose: analog source seen through the selected pin
// Assumes: the level is held steady for a whole conversion
// Notes: ideal comparator with no offset or noise
`timescale 1ns/1ns
module adcs_src_model (
  input wire logic [9:0] level_i,
  input wire logic [9:0] trial_i,
  output logic cmp_o
);
  // keep the trial bit while the held level reaches it
  assign cmp_o = level_i >= trial_i;
endmodule

// >>> test/adcs_seq_props.sv
// Purpose: port checks for the conversion sequencer
// Assumes: select field steady during a conversion
// Notes: length allows one extra bit period for tick phase
`timescale 1ns/1ns
module adcs_seq_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic converter_on_bit_i,
  input wire logic go_set_i,
  input wire logic go_clear_i,
  input wire logic [2:0] conv_clock_select_i,
  input wire logic result_justify_bit_i,
  input wire logic [7:0] analog_mask_i,
  input wire logic go_flag_o,
  input wire logic conversion_done_flag_o,
  input wire logic sampling_o,
  input wire logic [7:0] result_high_byte_o,
  input wire logic [7:0] result_low_byte_o,
  input wire logic [7:0] port_read_o
);
  logic [9:0] hi_cnt_r;
  int per_n;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // core cycles per bit period
  assign per_n = 1 << {conv_clock_select_i[1:0], conv_clock_select_i[2]};
  // cycles that go has stood high so far
  always_ff @(posedge core_clk_i) begin
    hi_cnt_r <= (rst_i || !go_flag_o) ? 10'h000 : hi_cnt_r + 10'h001;
  end
  sequence conv_end_s;
    $fell(go_flag_o) ##0 $rose(conversion_done_flag_o);
  endsequence
  go_start_a: assert property (
    go_set_i && sampling_o && converter_on_bit_i |=> go_flag_o) else $error("no start");
  hold_open_a: assert property (go_flag_o |-> !sampling_o)
    else $error("sampling mid conversion");
  abort_fast_a: assert property (go_flag_o && go_clear_i |=> !go_flag_o)
    else $error("abort too slow");
  abort_keep_a: assert property (go_flag_o && go_clear_i |=>
    ($stable(result_high_byte_o) && $stable(result_low_byte_o)) || $rose(conversion_done_flag_o))
    else $error("abort changed result");
  conv_len_a: assert property (conv_end_s |-> conv_clock_select_i[1:0] == 2'h3 ||
    (hi_cnt_r >= 12 * per_n && hi_cnt_r <= 13 * per_n)) else $error("bad length");
  justify_a: assert property (conv_end_s |-> (result_justify_bit_i ?
    result_high_byte_o[7:2] == 6'h00 : result_low_byte_o[5:0] == 6'h00)) else $error("justify");
  port_zero_a: assert property (
    $stable(analog_mask_i) |-> (port_read_o & analog_mask_i) == 8'h00) else $error("port");
  reset_off_a: assert property (disable iff (1'b0) rst_i |=> !go_flag_o && !sampling_o)
    else $error("reset did not stop");
endmodule
bind adcs_sequencer adcs_seq_props u_props (.core_clk_i, .rst_i, .converter_on_bit_i, .go_set_i,
  .go_clear_i, .conv_clock_select_i, .result_justify_bit_i, .analog_mask_i, .go_flag_o,
  .conversion_done_flag_o, .sampling_o, .result_high_byte_o, .result_low_byte_o, .port_read_o);

// >>> test/tb_top.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: rc source slow enough for a legal bit period
// Notes: result values are compared in rc mode only
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst = 1, on = 0, gs = 0, gc = 0, just = 0, rc = 0, wh = 0, dclr = 0, cmp, go;
  logic done, samp;
  logic [2:0] sel = 3'h0;
  logic [3:0] ch = 4'h0;
  logic [7:0] wd = 8'h00, pins = 8'h00, mask = 8'h00, rh, rl, pr;
  logic [9:0] tgt = 10'h000, dac;
  logic [31:0] seed = 32'ha2b5b10f;
  logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int err_total = 0;
  int check_count = 0;
  adcs_sequencer dut (.core_clk_i(clk), .rst_i(rst), .converter_on_bit_i(on), .go_set_i(gs),
    .go_clear_i(gc), .conv_clock_select_i(sel), .result_justify_bit_i(just),
    .channel_select_i(ch), .rc_osc_i(rc), .cmp_i(cmp), .result_wr_high_i(wh),
    .result_wr_low_i(wh), .result_wr_data_i(wd), .port_pins_i(pins), .analog_mask_i(mask),
    .done_flag_clear_i(dclr), .go_flag_o(go), .conversion_done_flag_o(done), .sampling_o(samp),
    .dac_code_o(dac), .result_high_byte_o(rh), .result_low_byte_o(rl), .port_read_o(pr));
  adcs_src_model src (.level_i(tgt), .trial_i(dac), .cmp_o(cmp));
  // 2 us rc period keeps the bit period above the legal minimum
  always #1000 rc = ~rc;
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize;
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for acquisition to resume
  task automatic waits(output int n);
    n = 0;
    while (samp !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      chk("timeout", 0, 1);
      summarize;
    end
  endtask
  // one conversion, aborted after ab cycles when ab is not negative
  task automatic run(input logic [2:0] s, input int ab);
    int n;
    int per;
    logic [31:0] r;
    logic [15:0] h0;
    per = 1 << {s[1:0], s[2]};
    r = xs();
    sel = s;
    just = r[31];
    tgt = r[9:0];
    ch = r[15:12];
    pins = r[23:16];
    mask = r[7:0] ^ r[31:24];
    wd = r[27:20];
    dclr = 1;
    wh = 1;
    @(negedge clk);
    dclr = 0;
    wh = 0;
    waits(n);
    repeat (4) @(negedge clk);
    chk("port", {8'h00, pins & ~mask}, {8'h00, pr});
    h0 = {rh, rl};
    chk("write", {wd, wd}, h0);
    gs = 1;
    @(negedge clk);
    n = 0;
    // a second start mid conversion must be ignored
    while (go === 1'b1 && n < 3000) begin
      gc = (n == ab);
      gs = (n == 5 && ab < 0);
      @(negedge clk);
      n++;
    end
    gc = 0;
    gs = 0;
    if (n >= 3000) begin
      chk("timeout", 0, 1);
      summarize;
    end
    if (ab >= 0) begin
      chk("abort_len", ab + 1, n);
      chk("kept", h0, {rh, rl});
      chk("done_abort", 0, done);
    end else begin
      chk("done", 1, done);
      if (s[1:0] == 2'h3) chk("result", just ? {6'h00, tgt} : {tgt, 6'h00}, {rh, rl});
      else chk("len", 1, n >= 12 * per && n <= 13 * per);
    end
    waits(n);
    if (s[1:0] != 2'h3) chk("gap", 1, n >= 2 * per);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    gs = 1;
    @(negedge clk);
    gs = 0;
    chk("go_off", 0, go);
    on = 1;
    foreach (codes[i]) run(codes[i], -1);
    run(3'h6, 3);
    run(3'h7, 40);
    run(3'h3, -1);
    gs = 1;
    @(negedge clk);
    gs = 0;
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk("reset", 0, {go, samp});
    summarize;
  end
endmodule
